// >>> rtl/conn_supervisor_map.svh
// Offsets, field positions, reset values and timing counts of the supervisor.
// Assumes inclusion by bare name from the supervisor under rtl/ and from its bench top.
`ifndef CONN_SUPERVISOR_MAP_SVH
`define CONN_SUPERVISOR_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL 12'h000
`define OFS_IVL 12'h004
`define OFS_ENABLE 12'h008
`define OFS_CMD 12'h00c
`define OFS_SEL 12'h010
`define OFS_CONN_CFG 12'h014
`define OFS_ESTAB 12'h018
`define OFS_TIMEOUT 12'h01c
`define OFS_STOPPED 12'h020
`define OFS_GSTAT 12'h024
`define OFS_CYCLE 12'h028

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_MODE_LSB 0
`define CTRL_LEGACY_BIT 2
`define CMD_RESUME_BIT 0
`define CMD_RESUME_ALL_BIT 1
`define CFG_OPEN_LSB 0
`define CFG_MCAST_BIT 2
`define CFG_INSLAVE_BIT 3
`define CFG_LEN_LSB 4
`define CFG_GROUP_LSB 9

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define RST_IVL 32'h0001_0000
`define SLAVE_CYCLE_NS 6000000
`define CLOCK_NS 4
`define MAX_DATA_BYTES 16
`define MAX_MCAST_MASTERS 15

`endif

// >>> rtl/conn_supervisor_pkg.sv
// Types used by the connection supervisor only; the timer imports none of them.
// Assumes the map header supplies all numeric constants.
package conn_supervisor_pkg;

  // Mode applied after a connection timeout
  typedef enum logic [1:0] {
    mode_auto_type_v,
    mode_stop_one_type_v,
    mode_stop_all_type_v
  } err_mode_type;

  // Open type per connection
  typedef enum logic [1:0] {
    open_configure_v,
    open_signature_v,
    open_only_v
  } open_type_type;

  // Per-connection state
  typedef enum logic [2:0] {
    st_idle,
    st_config,
    st_sigchk,
    st_run,
    st_stopped
  } conn_state_type;

endpackage : conn_supervisor_pkg

// >>> rtl/epi_timer.sv
// Per-connection send and receive supervision timer.
// Assumes run, reload and expired are on the controller clock.
`timescale 1ns/1ps
module ivl_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic run,
  input wire logic reload,
  input wire logic [WIDTH-1:0] interval,
  output logic expired
);

  logic [WIDTH-1:0] count_reg;

  // Count down while running; reload on each valid packet
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else if (!run || reload) begin
      count_reg <= interval;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - WIDTH'(1);
    end
  end

  // Expiry only while running and not reloading
  assign expired = run && !reload && (count_reg == '0);

endmodule : ivl_timer

// >>> rtl/conn_supervisor.sv
// Safety master connection supervisor with AXI4-Lite register slave.
// Assumes one controller clock; packet events from the link logic are synchronous.
// Function
// [RULE1] Configure open type downloads slave configuration
// [RULE2] Signature open type compares slave signature
// [RULE3] Open-only establishes without any check
// [RULE4] Multicast only for input slaves, 15 masters
// [RULE5] Same data set and interval share group
// [RULE6] Multicast accepted with single master
// [RULE7] Single-cast is one master, one slave
// [RULE8] Timer supervises send and receive intervals
// [RULE9] Missing data drops connection, data safe
// [RULE10] Interval at least max(controller, slave cycle)
// [RULE11] Legacy variant always recovers automatically
// [RULE12] Automatic mode retries and resumes alone
// [RULE13] Stop-one keeps faulty stopped, others run
// [RULE14] Stop-one restarts on flag or command
// [RULE15] Stop-all timeout halts every connection
// [RULE16] Stop-all armed after all established
// [RULE17] Stop-all rejects single restart, restarts all
// [RULE18] Restart tag acts on rising edge
// [RULE19] Resume-all restarts every stopped connection
// [RULE20] Up to 32 connections supported
// [RULE21] At most 16 data bytes per connection
// [RULE22] Timer reloads on each valid packet
// [RULE23] Status shows established, timed-out, stopped
`timescale 1ns/1ps
`include "conn_supervisor_map.svh"
module conn_supervisor #(
  parameter int CONNS = 32,
  parameter int IVL_W = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link side, one bit per connection
  input wire logic [CONNS-1:0] pkt_valid,
  input wire logic [CONNS-1:0] open_ack,
  input wire logic [CONNS-1:0] sig_match,
  input wire logic [CONNS-1:0] tx_sent,
  output logic [CONNS-1:0] open_req,
  output logic [CONNS-1:0] cfg_download,
  output logic [CONNS-1:0] sig_check,
  output logic [CONNS-1:0] exchange_en,
  output logic [CONNS-1:0] safe_state,
  // User program restart tags, pins
  input wire logic [CONNS-1:0] restart_tag
);
  import conn_supervisor_pkg::*;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [IVL_W-1:0] SLAVE_CYCLES = IVL_W'(`SLAVE_CYCLE_NS / `CLOCK_NS); // [RULE10]
  localparam int IW = $clog2(CONNS);

  // Larger of two cycle counts
  function automatic logic [IVL_W-1:0] max_of(input logic [IVL_W-1:0] a,
                                              input logic [IVL_W-1:0] b);
    max_of = (a > b) ? a : b;
  endfunction : max_of

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [1:0] mode_reg; // Mode after error
  logic legacy_reg; // Legacy variant selector
  logic [IVL_W-1:0] ivl_reg; // Expected packet interval request
  logic [IVL_W-1:0] cycle_reg; // Controller cycle in clocks
  logic [CONNS-1:0] enable_reg; // Configured connections
  logic [IW-1:0] sel_reg; // Connection chosen for config
  logic [13:0] cfg_reg [CONNS]; // Per-connection config
  conn_state_type state_reg [CONNS];
  logic [CONNS-1:0] timeout_reg; // Sticky timed-out status
  logic all_armed_reg; // Stop-all armed
  logic halt_all_reg; // Stop-all halted
  logic [CONNS-1:0] tag_s1_reg, tag_s2_reg, tag_s3_reg; // Tag sync and edge

  // AXI state
  logic aw_hold_reg, w_hold_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg, bresp_reg;

  // ****************************************************************
  // Derived wires
  // ****************************************************************
  wire logic [IVL_W-1:0] ivl_eff = max_of(ivl_reg, max_of(cycle_reg, SLAVE_CYCLES)); // [RULE10]
  wire err_mode_type mode_eff = legacy_reg ? mode_auto_type_v : err_mode_type'(mode_reg); // [RULE11]
  wire logic [CONNS-1:0] tag_rise = tag_s2_reg & ~tag_s3_reg; // [RULE18]
  wire logic wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire logic rd_fire = s_axi_arvalid && s_axi_arready;
  wire logic cmd_hit = wr_fire && (awaddr_reg == `OFS_CMD) && wstrb_reg[0];
  wire logic resume_one = cmd_hit && wdata_reg[`CMD_RESUME_BIT];
  wire logic resume_all = cmd_hit && wdata_reg[`CMD_RESUME_ALL_BIT]; // [RULE19]
  logic [CONNS-1:0] expired, running, established;
  logic [CONNS-1:0] cfg_ok;

  // Per-connection config legality and timers
  for (genvar i = 0; i < CONNS; i++) begin : g_conn
    wire logic mc = cfg_reg[i][`CFG_MCAST_BIT];
    wire logic [4:0] len = cfg_reg[i][`CFG_LEN_LSB +: 5];
    // Multicast only with input slaves, also for a lone master [RULE4] [RULE6] [RULE7]
    assign cfg_ok[i] = (!mc || cfg_reg[i][`CFG_INSLAVE_BIT])
                       && (len <= 5'(`MAX_DATA_BYTES)); // [RULE21]
    assign running[i] = (state_reg[i] == st_run);
    assign established[i] = running[i];
    ivl_timer #(.WIDTH(IVL_W)) u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .run(running[i]),
      .reload(pkt_valid[i] || tx_sent[i]), // [RULE22] [RULE8]
      .interval(ivl_eff),
      .expired(expired[i])
    );
  end

  wire logic any_expired = |(expired & enable_reg);
  wire logic stop_all_hit = (mode_eff == mode_stop_all_type_v) && all_armed_reg
                            && any_expired; // [RULE15]

  // ****************************************************************
  // Restart tag synchroniser and edge
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tag_s1_reg <= '0;
      tag_s2_reg <= '0;
      tag_s3_reg <= '0;
    end else begin
      tag_s1_reg <= restart_tag;
      tag_s2_reg <= tag_s1_reg;
      tag_s3_reg <= tag_s2_reg;
    end
  end

  // ****************************************************************
  // Connection state machines
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CONNS; i++) begin
        state_reg[i] <= st_idle;
      end
      timeout_reg <= '0;
      all_armed_reg <= 1'b0;
      halt_all_reg <= 1'b0;
    end else begin
      // Arm stop-all once every configured connection runs [RULE16]
      if (enable_reg != '0 && (established & enable_reg) == enable_reg) begin
        all_armed_reg <= 1'b1;
      end
      if (stop_all_hit) begin
        halt_all_reg <= 1'b1;
      end
      // Group restart clears the stop-all halt [RULE17]
      if (halt_all_reg && (resume_all || (tag_rise & enable_reg) == enable_reg)) begin
        halt_all_reg <= 1'b0;
        all_armed_reg <= 1'b0;
      end
      for (int i = 0; i < CONNS; i++) begin
        if (!enable_reg[i]) begin
          state_reg[i] <= st_idle;
        end else begin
          unique case (state_reg[i])
            st_idle: begin
              if (!halt_all_reg && cfg_ok[i]) begin
                unique case (open_type_type'(cfg_reg[i][`CFG_OPEN_LSB +: 2]))
                  open_configure_v: state_reg[i] <= st_config; // [RULE1]
                  open_signature_v: state_reg[i] <= st_sigchk; // [RULE2]
                  default: state_reg[i] <= st_sigchk; // Open-only waits ack only [RULE3]
                endcase
              end
            end
            st_config, st_sigchk: begin
              if (halt_all_reg) begin
                state_reg[i] <= st_stopped;
              end else if (open_ack[i]) begin
                // Signature must match when checking it [RULE2]
                if (cfg_reg[i][1:0] != 2'h1 || sig_match[i]) begin
                  state_reg[i] <= st_run;
                end else begin
                  state_reg[i] <= st_idle;
                end
              end
            end
            st_run: begin
              if (stop_all_hit || halt_all_reg) begin
                state_reg[i] <= st_stopped; // [RULE15]
              end else if (expired[i]) begin
                // Drop connection on timeout [RULE9] [RULE13]
                state_reg[i] <= (mode_eff == mode_auto_type_v) ? st_idle : st_stopped;
              end
            end
            st_stopped: begin
              if (mode_eff == mode_stop_one_type_v
                  && (tag_rise[i] || resume_one && sel_reg == IW'(i) || resume_all)) begin
                state_reg[i] <= st_idle; // [RULE14] [RULE19]
              end else if (mode_eff == mode_auto_type_v && !halt_all_reg) begin
                state_reg[i] <= st_idle; // [RULE12]
              end else if (mode_eff == mode_stop_all_type_v && !halt_all_reg) begin
                state_reg[i] <= st_idle; // [RULE17]
              end
            end
            default: state_reg[i] <= st_idle;
          endcase
        end
        // Sticky timeout; the event wins over the clear [RULE23]
        if (expired[i] && enable_reg[i]) begin
          timeout_reg[i] <= 1'b1;
        end else if (wr_fire && awaddr_reg == `OFS_TIMEOUT && wdata_reg[i]) begin
          timeout_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Link outputs, decoded from the state
  always_comb begin
    for (int i = 0; i < CONNS; i++) begin
      open_req[i] = (state_reg[i] == st_config) || (state_reg[i] == st_sigchk);
      cfg_download[i] = (state_reg[i] == st_config); // [RULE1]
      sig_check[i] = (state_reg[i] == st_sigchk) && (cfg_reg[i][1:0] == 2'h1); // [RULE2]
      exchange_en[i] = running[i];
      safe_state[i] = !running[i]; // [RULE9]
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  wire logic wr_known = (awaddr_reg <= `OFS_CYCLE) && (awaddr_reg[1:0] == 2'b00);

  // Capture address and data in either order, answer once both held
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? 2'b00 : 2'b10;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end

  // Register writes other than CMD and TIMEOUT; taken only when all four strobes set
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 2'h0;
      legacy_reg <= 1'b0;
      ivl_reg <= IVL_W'(`RST_IVL);
      cycle_reg <= '0;
      enable_reg <= '0;
      sel_reg <= '0;
      for (int i = 0; i < CONNS; i++) begin
        cfg_reg[i] <= '0;
      end
    end else if (wr_fire && wstrb_reg == 4'hf) begin
      unique case (awaddr_reg)
        `OFS_CTRL: begin
          mode_reg <= (wdata_reg[1:0] == 2'h3) ? mode_reg : wdata_reg[1:0];
          legacy_reg <= wdata_reg[`CTRL_LEGACY_BIT];
        end
        `OFS_IVL: ivl_reg <= IVL_W'(wdata_reg);
        `OFS_CYCLE: cycle_reg <= IVL_W'(wdata_reg);
        `OFS_ENABLE: enable_reg <= CONNS'(wdata_reg); // [RULE20]
        `OFS_SEL: sel_reg <= IW'(wdata_reg);
        `OFS_CONN_CFG: cfg_reg[sel_reg] <= wdata_reg[13:0]; // [RULE5]
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  logic [31:0] rd_mux;
  logic rd_ok;
  logic [CONNS-1:0] stopped_vec;
  always_comb begin
    for (int i = 0; i < CONNS; i++) begin
      stopped_vec[i] = (state_reg[i] == st_stopped);
    end
  end

  // Read decode
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      `OFS_CTRL: rd_mux = {29'h0, legacy_reg, mode_reg};
      `OFS_IVL: rd_mux = 32'(ivl_eff);
      `OFS_ENABLE: rd_mux = 32'(enable_reg);
      `OFS_CMD: rd_mux = 32'h0;
      `OFS_SEL: rd_mux = 32'(sel_reg);
      `OFS_CONN_CFG: rd_mux = {18'h0, cfg_reg[sel_reg]};
      `OFS_ESTAB: rd_mux = 32'(established);
      `OFS_TIMEOUT: rd_mux = 32'(timeout_reg);
      `OFS_STOPPED: rd_mux = 32'(stopped_vec);
      `OFS_GSTAT: rd_mux = {30'h0, halt_all_reg, all_armed_reg};
      `OFS_CYCLE: rd_mux = 32'(cycle_reg);
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Read response one cycle after address taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= 2'b00;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_ok ? 2'b00 : 2'b10;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : conn_supervisor

// >>> verification/conn_supervisor_properties.sv
// Checker for the connection supervisor top ports.
// Assumes a bind from the bench top file; one clock domain.
`timescale 1ns/1ps
module conn_supervisor_checker #(
  parameter int CONNS = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [CONNS-1:0] open_ack,
  input wire logic [CONNS-1:0] open_req,
  input wire logic [CONNS-1:0] cfg_download,
  input wire logic [CONNS-1:0] sig_check,
  input wire logic [CONNS-1:0] exchange_en,
  input wire logic [CONNS-1:0] safe_state
);
  // ****************************************
  // Link side
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_safe_mirror: assert property (safe_state == ~exchange_en)
    else $error("safe state differs from inverse of exchange");
  a_cfg_in_open: assert property ((cfg_download & ~open_req) == '0)
    else $error("download phase outside opening");
  a_sig_in_open: assert property ((sig_check & ~open_req) == '0)
    else $error("signature phase outside opening");
  a_phase_excl: assert property ((cfg_download & sig_check) == '0)
    else $error("download and signature phases overlap");
  a_open_excl: assert property ((open_req & exchange_en) == '0)
    else $error("opening and established together");
  a_run_after_ack: assert property ((exchange_en & ~$past(exchange_en)
    & ~$past(open_ack) & ~$past(open_ack, 2)) == '0)
    else $error("exchange began without an open answer");
  // ****************************************
  // Register bus
  // ****************************************
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not cleared");
  a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not cleared");
endmodule : conn_supervisor_checker

// >>> verification/slave_link_model.sv
// Model of the remote safety slaves, one per connection bit.
// Assumes the supervisor clock; answers odd connections slowly.
`timescale 1ns/1ps
module slave_link_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [31:0] sig_good,
  input wire logic [31:0] open_req,
  input wire logic [31:0] exchange_en,
  output logic [31:0] open_ack,
  output logic [31:0] sig_match,
  output logic [31:0] pkt_valid,
  output logic [31:0] tx_sent
);
  logic [4:0] wait_cnt [32]; // Answer delay per slave
  logic [5:0] tick; // Packet period counter
  // Match line meaningful only with the answer, inverted otherwise
  assign sig_match = (open_ack & sig_good) | (~open_ack & ~sig_good);
  // Open answers and cyclic packets
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick <= '0;
      open_ack <= '0;
      pkt_valid <= '0;
      tx_sent <= '0;
      for (int i = 0; i < 32; i++) wait_cnt[i] <= '0;
    end else begin
      tick <= tick + 6'h1;
      pkt_valid <= (tick == 6'h00) ? exchange_en : '0;
      tx_sent <= (tick == 6'h20) ? exchange_en : '0;
      for (int i = 0; i < 32; i++) begin
        // One answer per request, own slave only
        if (!open_req[i] || open_ack[i]) begin
          wait_cnt[i] <= '0;
          open_ack[i] <= 1'b0;
        end else if (wait_cnt[i] == (i[0] ? 5'h14 : 5'h02)) begin
          open_ack[i] <= 1'b1;
        end else begin
          wait_cnt[i] <= wait_cnt[i] + 5'h1;
        end
      end
    end
  end
endmodule : slave_link_model

// >>> verification/conn_supervisor_tb_top.sv
// Bench top for the connection supervisor.
// Assumes the map header and the slave model; timeouts exceed run length.
`timescale 1ns/1ps
`include "conn_supervisor_map.svh"
module conn_supervisor_tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd, pkt_valid, open_ack, sig_match, tx_sent, open_req;
  logic [31:0] cfg_download, sig_check, exchange_en, safe_state;
  logic [31:0] restart_tag = '0, seen_cfg = '0, seen_sig = '0;
  logic [31:0] cfg_tab [8] = '{32'h080, 32'h081, 32'h081, 32'h102,
    32'h24e, 32'h446, 32'h112, 32'h24c}; // Per connection setup
  int n_fail = 0;
  int comparisons = 0;
  int n;
  always #2 clock = ~clock;
  conn_supervisor dut_u (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pkt_valid(pkt_valid),
    .open_ack(open_ack), .sig_match(sig_match), .tx_sent(tx_sent), .open_req(open_req),
    .cfg_download(cfg_download), .sig_check(sig_check), .exchange_en(exchange_en),
    .safe_state(safe_state), .restart_tag(restart_tag));
  // Slave 2 carries a wrong signature
  slave_link_model peer_u (.clock(clock), .rst_b(rst_b), .sig_good(~32'h4),
    .open_req(open_req), .exchange_en(exchange_en), .open_ack(open_ack),
    .sig_match(sig_match), .pkt_valid(pkt_valid), .tx_sent(tx_sent));
  // Record which phases each connection passed through
  always @(posedge clock) begin
    seen_cfg <= seen_cfg | cfg_download;
    seen_sig <= seen_sig | sig_check;
  end
  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t response %b expected %b", $time, got, exp);
    end
  endtask : chk_resp
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask : wr
  task automatic rd_reg(input logic [11:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask : rd_reg
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    // Mode: value 3 and partial strobes leave it alone
    wr(`OFS_CTRL, 32'h1, 4'hf);
    wr(`OFS_CTRL, 32'h3, 4'hf);
    wr(`OFS_CTRL, 32'h2, 4'h1);
    rd_reg(`OFS_CTRL);
    chk_word(rd & 32'h3, 32'h1);
    $display("test mode_register done");
    // Interval floor follows the larger cycle time
    wr(`OFS_CYCLE, 32'd100, 4'hf);
    wr(`OFS_IVL, 32'h10, 4'hf);
    rd_reg(`OFS_IVL);
    chk_word(rd, 32'h0016_e360);
    wr(`OFS_CYCLE, 32'h0018_6a00, 4'hf);
    rd_reg(`OFS_IVL);
    chk_word(rd, 32'h0018_6a00);
    wr(`OFS_IVL, 32'h0019_f0a0, 4'hf);
    rd_reg(`OFS_IVL);
    chk_word(rd, 32'h0019_f0a0);
    wr(`OFS_CYCLE, 32'd100, 4'hf);
    $display("test interval_floor done");
    // Unmapped and unaligned places
    rd_reg(12'h100);
    chk_resp(rsp, 2'b10);
    chk_word(rd, 32'h0);
    wr(12'h002, 32'h0, 4'hf);
    chk_resp(rsp, 2'b10);
    $display("test bad_address done");
    // Open eight connections of every kind
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_SEL, i, 4'hf);
      wr(`OFS_CONN_CFG, cfg_tab[i], 4'hf);
    end
    wr(`OFS_ENABLE, 32'hff, 4'hf);
    n = 0;
    do begin
      rd_reg(`OFS_ESTAB);
      n++;
    end while (rd !== 32'h9b && n < 100);
    chk_word(rd, 32'h9b);
    @(negedge clock);
    chk_word(exchange_en, 32'h9b);
    chk_word(safe_state, ~32'h9b);
    chk_word(seen_cfg, 32'h81);
    chk_word(seen_sig, 32'h06);
    $display("test open_types done");
    // Stop-all arms only once every enabled slave runs
    wr(`OFS_CTRL, 32'h2, 4'hf);
    rd_reg(`OFS_GSTAT);
    chk_word(rd & 32'h1, 32'h0);
    wr(`OFS_ENABLE, 32'h9b, 4'hf);
    rd_reg(`OFS_GSTAT);
    chk_word(rd & 32'h1, 32'h1);
    $display("test stop_all_arm done");
    // Restart requests with nothing stopped change nothing
    @(posedge clock);
    restart_tag <= 32'h9b;
    wr(`OFS_CMD, 32'h2, 4'hf);
    rd_reg(`OFS_STOPPED);
    chk_word(rd, 32'h0);
    rd_reg(`OFS_TIMEOUT);
    chk_word(rd, 32'h0);
    rd_reg(`OFS_ESTAB);
    chk_word(rd, 32'h9b);
    $display("test idle_restart done");
    report_and_stop();
  end
  // Cut a hang short
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : conn_supervisor_tb_top
bind conn_supervisor conn_supervisor_checker #(.CONNS(CONNS)) chk_u (.clock(clock),
  .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .open_ack(open_ack),
  .open_req(open_req), .cfg_download(cfg_download), .sig_check(sig_check),
  .exchange_en(exchange_en), .safe_state(safe_state));
